// ===== rtl/ecsu_top.sv
// The implementer's own choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ns
// How it works
// - Sixteen cam slots, each with start, end, action; a 4-bit count evaluates fifteen at most.
// - Positions take full range, order unchecked.
// - Action word picks outputs and flags.
// - Cycle counts user units, wraps at length.
// - Without units, 65536 increments per revolution.
// - Evaluate configured count; zero means idle.
// - Hysteresis widens active cams against jitter.
// - Source zero follows own position.
// - Source one follows master encoder.
// - Pin or flag 75 rise starts unit.
// - Start edge clears cycle position.
// - Pin falling edge stops the unit.
// - Flag 75 fall stops flag-started unit.
// - Writing zero count stops the unit.
// - No messages sent, only flags/outputs.
// - Flags 98/99, virtual outputs raise event.
// - Two flag numbers 0..99 per action.
// - Selected outputs driven while cam active.
module ecsu_top (
	input  wire logic        clk,             // Control clock, 125 MHz.
	input  wire logic        rst,             // Asynchronous reset.
	input  wire logic [8:0]  avs_address,     // Byte address.
	input  wire logic        avs_read,        // Read request.
	input  wire logic        avs_write,       // Write request.
	input  wire logic [31:0] avs_writedata,   // Write data.
	output logic      [31:0] avs_readdata,    // Read data.
	output logic             avs_waitrequest, // Slave stall.
	input  wire logic        ctrl_tick,       // Control cycle pulse.
	input  wire logic [31:0] own_position,    // Position controller.
	input  wire logic [31:0] master_position, // Master encoder.
	input  wire logic        cam_start_pin,   // Start input pin.
	input  wire logic        seq_flag75,      // Sequence flag 75.
	output logic      [15:0] cam_active_flag, // Active cams.
	output logic      [15:0] cam_outputs,     // Switching points.
	output logic      [99:0] prog_flags,      // Program flags set.
	output logic             can_event        // Event request pulse.
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	logic [3:0]  cnt_r;
	logic        src_r;
	logic        unit_r;
	logic [31:0] cyc_len_r;
	logic [31:0] hys_r;
	logic        running_r;
	logic        by_flag_r;
	logic        f75_q_r;
	logic [31:0] cyc_pos_r;
	logic [31:0] last_pos_r;
	ecsu_pkg::ecsu_scan_e st_r;
	logic [3:0]  idx_r;
	logic [31:0] start_r;
	logic [31:0] end_r;
	logic [15:0] act_acc_r;
	logic [15:0] out_acc_r;
	logic [99:0] flag_acc_r;
	logic [15:0] act_r;
	logic [15:0] out_r;
	logic [99:0] flags_r;
	logic        can_r;
	ecsu_pkg::ecsu_rd_e rd_st_r;
	logic [31:0] readdata_r;

	logic        pin_rise;
	logic        pin_fall;
	logic        f75_rise;
	logic        f75_fall;
	logic        wr_ctrl;
	logic        start_ev;
	logic        stop_ev;
	logic [31:0] pos_sel;
	logic [32:0] len_w;
	logic [31:0] delta;
	logic [33:0] sum;
	logic [33:0] pos_nxt;
	logic        kick;
	logic        last_cam;
	logic        hit;
	logic [15:0] act_nxt;
	logic [15:0] out_nxt;
	logic [99:0] flag_nxt;
	logic        tbl;
	logic [31:0] reg_val;

	ecsu_mem_if mif ();

	ecsu_cam_mem u_mem (
		.clk (clk),
		.mp  (mif.mem)
	);

	ecsu_start_sync u_sync (
		.clk  (clk),
		.rst  (rst),
		.pin  (cam_start_pin),
		.rise (pin_rise),
		.fall (pin_fall)
	);

	// One-hot mask for a program flag number, empty when off or above 99.
	function automatic logic [99:0] flag_mask(input logic [6:0] n,
		input logic en);
		logic [99:0] m;
		m = '0;
		if (en && n <= ecsu_pkg::FLAG_MAX) begin
			m[n] = 1'b1;
		end
		return m;
	endfunction

	// Window test with hysteresis; a start above the end wraps the cycle.
	function automatic logic cam_hit(input logic [31:0] p,
		input logic [31:0] s, input logic [31:0] e,
		input logic [31:0] h, input logic was);
		logic signed [33:0] lo;
		logic signed [33:0] hi;
		logic signed [33:0] ps;
		ps = $signed({2'b00, p});
		lo = $signed({2'b00, s}) - (was ? $signed({2'b00, h}) : 34'sh0);
		hi = $signed({2'b00, e}) + (was ? $signed({2'b00, h}) : 34'sh0);
		if (s <= e) begin
			return (ps >= lo) && (ps <= hi);
		end
		return (ps >= lo) || (ps <= hi);
	endfunction

	// Start and stop events; a stop wins over a start in one cycle.
	assign f75_rise = seq_flag75 & ~f75_q_r;
	assign f75_fall = ~seq_flag75 & f75_q_r;
	assign wr_ctrl  = avs_write && avs_address == ecsu_pkg::OFF_CTRL;
	assign start_ev = (pin_rise | f75_rise) && cnt_r != 4'h0;
	assign stop_ev  = pin_fall
		| (f75_fall & by_flag_r)
		| (wr_ctrl && avs_writedata[3:0] == 4'h0);

	// Position source, cycle length and wrapped next position.
	assign pos_sel = (src_r == ecsu_pkg::SRC_MASTER) ? master_position
		: own_position;
	assign len_w = unit_r ? {1'b0, cyc_len_r}
		: ecsu_pkg::RAW_CYCLE;
	assign delta = pos_sel - last_pos_r;
	assign sum   = {2'b00, cyc_pos_r} + {{2{delta[31]}}, delta};
	always_comb begin
		pos_nxt = sum;
		if (sum[33]) begin
			pos_nxt = sum + {1'b0, len_w};
		end else if (sum >= {1'b0, len_w}) begin
			pos_nxt = sum - {1'b0, len_w};
		end
	end

	// Run state and the origin of the start.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			running_r <= 1'b0;
			by_flag_r <= 1'b0;
			f75_q_r   <= 1'b0;
		end else begin
			f75_q_r <= seq_flag75;
			if (stop_ev) begin
				running_r <= 1'b0;
			end else if (start_ev) begin
				running_r <= 1'b1;
				by_flag_r <= ~pin_rise;
			end
		end
	end

	// Cycle position follows the source and restarts on a start edge.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cyc_pos_r  <= ecsu_pkg::RST_WORD;
			last_pos_r <= ecsu_pkg::RST_WORD;
		end else if (start_ev && !stop_ev) begin
			cyc_pos_r  <= ecsu_pkg::RST_WORD;
			last_pos_r <= pos_sel;
		end else if (ctrl_tick) begin
			last_pos_r <= pos_sel;
			if (running_r) begin
				cyc_pos_r <= pos_nxt[31:0];
			end
		end
	end

	// Scan over the configured cams once per control cycle.
	assign kick     = ctrl_tick && running_r && st_r == ecsu_pkg::SC_IDLE;
	assign last_cam = {1'b0, idx_r} + 5'h01 >= {1'b0, cnt_r};
	assign hit = cam_hit(cyc_pos_r, start_r, end_r, hys_r,
		act_r[idx_r]);
	assign act_nxt = act_acc_r | ({15'h0, hit} << idx_r);
	assign out_nxt = out_acc_r
		| (hit ? mif.rdata[31:16] : 16'h0);
	assign flag_nxt = flag_acc_r | (hit ? (flag_mask(
		mif.rdata[ecsu_pkg::ACT_F1_LSB +: 7],
		mif.rdata[ecsu_pkg::ACT_F1_EN])
		| flag_mask(mif.rdata[ecsu_pkg::ACT_F2_LSB +: 7],
		mif.rdata[ecsu_pkg::ACT_F2_EN])) : 100'h0);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_r       <= ecsu_pkg::SC_IDLE;
			idx_r      <= 4'h0;
			start_r    <= ecsu_pkg::RST_WORD;
			end_r      <= ecsu_pkg::RST_WORD;
			act_acc_r  <= 16'h0;
			out_acc_r  <= 16'h0;
			flag_acc_r <= 100'h0;
		end else begin
			case (st_r)
				ecsu_pkg::SC_IDLE: begin
					if (kick) begin
						idx_r      <= 4'h0;
						act_acc_r  <= 16'h0;
						out_acc_r  <= 16'h0;
						flag_acc_r <= 100'h0;
						st_r       <= ecsu_pkg::SC_RD_S;
					end
				end
				ecsu_pkg::SC_RD_S: st_r <= ecsu_pkg::SC_RD_E;
				ecsu_pkg::SC_RD_E: begin
					start_r <= mif.rdata;
					st_r    <= ecsu_pkg::SC_RD_A;
				end
				ecsu_pkg::SC_RD_A: begin
					end_r <= mif.rdata;
					st_r  <= ecsu_pkg::SC_EVAL;
				end
				ecsu_pkg::SC_EVAL: begin
					act_acc_r  <= act_nxt;
					out_acc_r  <= out_nxt;
					flag_acc_r <= flag_nxt;
					idx_r      <= idx_r + 4'h1;
					st_r <= last_cam ? ecsu_pkg::SC_IDLE
						: ecsu_pkg::SC_RD_S;
				end
				default: st_r <= ecsu_pkg::SC_IDLE;
			endcase
		end
	end

	// Commit results at the end of a scan; a stopped unit releases all.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			act_r   <= 16'h0;
			out_r   <= 16'h0;
			flags_r <= 100'h0;
			can_r   <= 1'b0;
		end else if (!running_r) begin
			act_r   <= 16'h0;
			out_r   <= 16'h0;
			flags_r <= 100'h0;
			can_r   <= 1'b0;
		end else if (st_r == ecsu_pkg::SC_EVAL && last_cam) begin
			act_r   <= act_nxt;
			out_r   <= out_nxt;
			flags_r <= flag_nxt;
			can_r   <= (flag_nxt[ecsu_pkg::FLAG_EV_A]
				& ~flags_r[ecsu_pkg::FLAG_EV_A])
				| (flag_nxt[ecsu_pkg::FLAG_EV_B]
				& ~flags_r[ecsu_pkg::FLAG_EV_B])
				| (out_nxt[ecsu_pkg::OUT_VIRT_A]
				& ~out_r[ecsu_pkg::OUT_VIRT_A])
				| (out_nxt[ecsu_pkg::OUT_VIRT_B]
				& ~out_r[ecsu_pkg::OUT_VIRT_B]);
		end else begin
			can_r <= 1'b0;
		end
	end

	// Configuration writes; writes never stall.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_r     <= ecsu_pkg::RST_CNT;
			src_r     <= ecsu_pkg::SRC_OWN;
			unit_r    <= 1'b0;
			cyc_len_r <= ecsu_pkg::RST_WORD;
			hys_r     <= ecsu_pkg::RST_WORD;
		end else if (avs_write) begin
			if (avs_address == ecsu_pkg::OFF_CTRL) begin
				cnt_r  <= avs_writedata[3:0];
				src_r  <= avs_writedata[ecsu_pkg::CTRL_SRC_BIT];
				unit_r <= avs_writedata[ecsu_pkg::CTRL_UNIT_BIT];
			end else if (avs_address == ecsu_pkg::OFF_CYCLE) begin
				cyc_len_r <= avs_writedata;
			end else if (avs_address == ecsu_pkg::OFF_HYST) begin
				hys_r <= avs_writedata;
			end
		end
	end

	// Table port: bus writes anytime, bus reads only while scan is idle.
	assign tbl       = avs_address[ecsu_pkg::TABLE_BIT];
	assign mif.we    = avs_write && tbl;
	assign mif.waddr = avs_address[7:2];
	assign mif.wdata = avs_writedata;
	always_comb begin
		mif.raddr = {idx_r, ecsu_pkg::WORD_START};
		if (st_r == ecsu_pkg::SC_IDLE) begin
			mif.raddr = avs_address[7:2];
		end else if (st_r == ecsu_pkg::SC_RD_E) begin
			mif.raddr = {idx_r, ecsu_pkg::WORD_END};
		end else if (st_r == ecsu_pkg::SC_RD_A) begin
			mif.raddr = {idx_r, ecsu_pkg::WORD_ACT};
		end
	end

	// Register read mux; unmapped words read zero.
	always_comb begin
		reg_val = ecsu_pkg::RST_WORD;
		if (avs_address == ecsu_pkg::OFF_CTRL) begin
			reg_val = {26'h0, unit_r, src_r, cnt_r};
		end else if (avs_address == ecsu_pkg::OFF_CYCLE) begin
			reg_val = cyc_len_r;
		end else if (avs_address == ecsu_pkg::OFF_HYST) begin
			reg_val = hys_r;
		end else if (avs_address == ecsu_pkg::OFF_STAT) begin
			reg_val = {act_r, 14'h0, by_flag_r, running_r};
		end else if (avs_address == ecsu_pkg::OFF_POS) begin
			reg_val = cyc_pos_r;
		end else if (avs_address == ecsu_pkg::OFF_OUTS) begin
			reg_val = {16'h0, out_r};
		end
	end

	// Read sequencer: answer from a register one or more cycles later.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rd_st_r    <= ecsu_pkg::RB_IDLE;
			readdata_r <= ecsu_pkg::RST_WORD;
		end else begin
			case (rd_st_r)
				ecsu_pkg::RB_IDLE: begin
					if (avs_read && !tbl) begin
						readdata_r <= reg_val;
						rd_st_r    <= ecsu_pkg::RB_DONE;
					end else if (avs_read && !kick
						&& st_r == ecsu_pkg::SC_IDLE) begin
						rd_st_r <= ecsu_pkg::RB_MEM;
					end
				end
				ecsu_pkg::RB_MEM: begin
					readdata_r <= mif.rdata;
					rd_st_r    <= ecsu_pkg::RB_DONE;
				end
				default: rd_st_r <= ecsu_pkg::RB_IDLE;
			endcase
		end
	end

	assign avs_waitrequest = avs_read && rd_st_r != ecsu_pkg::RB_DONE;
	assign avs_readdata    = readdata_r;
	assign cam_active_flag = act_r;
	assign cam_outputs     = out_r;
	assign prog_flags      = flags_r;
	assign can_event       = can_r;

	// Checks on the run control, position and scan.
	sequence s_kick;
		kick;
	endsequence
	sequence s_scan_done;
		##[4:64] (st_r == ecsu_pkg::SC_IDLE);
	endsequence
	property p_zero_idle;
		cnt_r == 4'h0 |-> !running_r;
	endproperty
	a_zero_idle: assert property (p_zero_idle)
		else $error("unit runs with zero cams");
	property p_start;
		start_ev && !stop_ev |=> running_r && cyc_pos_r == 32'h0;
	endproperty
	a_start: assert property (p_start)
		else $error("start edge did not start at origin");
	property p_pin_stop;
		pin_fall |=> !running_r;
	endproperty
	a_pin_stop: assert property (p_pin_stop)
		else $error("pin fall did not stop");
	property p_flag_stop;
		f75_fall && by_flag_r |=> !running_r;
	endproperty
	a_flag_stop: assert property (p_flag_stop)
		else $error("flag fall did not stop");
	property p_wrap;
		ctrl_tick && running_r && !start_ev && !stop_ev && !avs_write
		&& len_w != 33'h0 && cyc_pos_r < len_w[31:0]
		|=> {1'b0, cyc_pos_r} < $past(len_w);
	endproperty
	a_wrap: assert property (p_wrap)
		else $error("cycle position beyond cycle length");
	property p_release;
		!running_r |=> act_r == 16'h0 && out_r == 16'h0
			&& flags_r == 100'h0 && !can_r;
	endproperty
	a_release: assert property (p_release)
		else $error("outputs held after stop");
	property p_event;
		$rose(flags_r[ecsu_pkg::FLAG_EV_A])
		|| $rose(flags_r[ecsu_pkg::FLAG_EV_B])
		|| $rose(out_r[ecsu_pkg::OUT_VIRT_A])
		|| $rose(out_r[ecsu_pkg::OUT_VIRT_B]) |-> can_r;
	endproperty
	a_event: assert property (p_event)
		else $error("event flag set without event pulse");
	property p_scan;
		s_kick |-> s_scan_done;
	endproperty
	a_scan: assert property (p_scan)
		else $error("cam scan did not finish in time");
endmodule

// ===== rtl/ecsu_pkg.sv
package ecsu_pkg;

	// Table geometry: sixteen cam slots, three words each in a 4-word slot.
	localparam int NCAM   = 16;
	localparam int CNT_W  = 4;
	localparam int MEM_AW = 6;
	localparam int NFLAG  = 100;
	localparam int NOUT   = 16;

	// Register byte offsets on the slave port.
	localparam logic [8:0] OFF_CTRL  = 9'h000;
	localparam logic [8:0] OFF_CYCLE = 9'h004;
	localparam logic [8:0] OFF_HYST  = 9'h008;
	localparam logic [8:0] OFF_STAT  = 9'h00c;
	localparam logic [8:0] OFF_POS   = 9'h010;
	localparam logic [8:0] OFF_OUTS  = 9'h014;
	localparam int         TABLE_BIT = 8;

	// Control register fields.
	localparam int CTRL_SRC_BIT  = 4;
	localparam int CTRL_UNIT_BIT = 5;

	// Words inside one cam slot.
	localparam logic [1:0] WORD_START = 2'h0;
	localparam logic [1:0] WORD_END   = 2'h1;
	localparam logic [1:0] WORD_ACT   = 2'h2;

	// Action word fields.
	localparam int ACT_F1_LSB = 0;
	localparam int ACT_F1_EN  = 7;
	localparam int ACT_F2_LSB = 8;
	localparam int ACT_F2_EN  = 15;
	localparam int ACT_O_LSB  = 16;

	// Flag numbers and outputs that raise the fieldbus event.
	localparam logic [6:0] FLAG_MAX   = 7'h63;
	localparam int         FLAG_EV_A  = 98;
	localparam int         FLAG_EV_B  = 99;
	localparam int         OUT_VIRT_A = 0;
	localparam int         OUT_VIRT_B = 1;

	// Cycle length in raw increments, one motor revolution.
	localparam logic [32:0] RAW_CYCLE = 33'h0_0001_0000;

	// Reset values.
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [3:0]  RST_CNT  = 4'h0;

	// Position source codes.
	localparam logic SRC_OWN    = 1'b0;
	localparam logic SRC_MASTER = 1'b1;

	typedef enum logic [2:0] {
		SC_IDLE  = 3'b000,
		SC_RD_S  = 3'b001,
		SC_RD_E  = 3'b011,
		SC_RD_A  = 3'b010,
		SC_EVAL  = 3'b110
	} ecsu_scan_e;

	typedef enum logic [1:0] {
		RB_IDLE = 2'b00,
		RB_MEM  = 2'b01,
		RB_DONE = 2'b11
	} ecsu_rd_e;

endpackage

// ===== rtl/ecsu_mem_if.sv
`timescale 1ns/1ns
// Write and read ports of the cam table.
interface ecsu_mem_if;
	logic        we;
	logic [5:0]  waddr;
	logic [31:0] wdata;
	logic [5:0]  raddr;
	logic [31:0] rdata;
	modport ctl (output we, waddr, wdata, raddr, input rdata);
	modport mem (input we, waddr, wdata, raddr, output rdata);
endinterface

// ===== rtl/ecsu_cam_mem.sv
`timescale 1ns/1ns
// Cam table storage with one write port and one registered read port.
module ecsu_cam_mem (
	input wire logic clk, // Control clock.
	ecsu_mem_if.mem  mp   // Table ports.
);
	logic [31:0] mem_q [64];
	logic [31:0] rdata_r;

	// Write and registered read; the table holds no reset value.
	always_ff @(posedge clk) begin
		if (mp.we) begin
			mem_q[mp.waddr] <= mp.wdata;
		end
		rdata_r <= mem_q[mp.raddr];
	end

	assign mp.rdata = rdata_r;
endmodule

// ===== rtl/ecsu_start_sync.sv
`timescale 1ns/1ns
// Two-flop synchroniser and edge detector for the start pin.
module ecsu_start_sync (
	input  wire logic clk,  // Control clock.
	input  wire logic rst,  // Asynchronous reset.
	input  wire logic pin,  // Raw pin level.
	output logic      rise, // One-cycle pulse on a rising edge.
	output logic      fall  // One-cycle pulse on a falling edge.
);
	logic s1_r;
	logic s2_r;
	logic s3_r;

	// The first flop feeds only the second.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
		end else begin
			s1_r <= pin;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	assign rise = s2_r & ~s3_r;
	assign fall = ~s2_r & s3_r;
endmodule

// ===== verif/ecsu_partner.sv
`timescale 1ns/1ns
// Position sources and control-cycle generator facing the cam unit.
module ecsu_partner (
	input  wire logic        clk,             // Control clock.
	input  wire logic        rst,             // Asynchronous reset.
	input  wire logic        tick_req,        // Request one control cycle.
	input  wire logic [31:0] own_step,        // Own advance per cycle.
	input  wire logic [31:0] mst_step,        // Master advance per cycle.
	output logic             ctrl_tick,       // Control cycle pulse.
	output logic      [31:0] own_position,    // Controller position.
	output logic      [31:0] master_position  // Master encoder position.
);
	// The tick and the moved position appear on the same edge, so the
	// unit samples the new position together with the tick.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl_tick <= 1'b0;
		end else begin
			ctrl_tick <= tick_req;
		end
	end

	// Both sources advance on every requested cycle; only one is followed.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			own_position    <= 32'h0000_0000;
			master_position <= 32'h0000_0000;
		end else if (tick_req) begin
			own_position    <= own_position + own_step;
			master_position <= master_position + mst_step;
		end
	end
endmodule

// ===== verif/ecsu_top_tb.sv
`timescale 1ns/1ns
// Self-checking bench: bus tasks, control cycles and expected values.
module ecsu_top_tb;
	logic        clk;
	logic        rst;
	logic [8:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        ctrl_tick;
	logic [31:0] own_position;
	logic [31:0] master_position;
	logic        cam_start_pin;
	logic        seq_flag75;
	logic [15:0] cam_active_flag;
	logic [15:0] cam_outputs;
	logic [99:0] prog_flags;
	logic        can_event;
	logic        tick_req;
	logic [31:0] own_step;
	logic [31:0] mst_step;
	logic [31:0] p;
	logic        a0;
	logic        a1;
	int          bad_count = 0;
	int          tests_run = 0;
	int          ev_cnt = 0;

	ecsu_top uut (
		.clk(clk), .rst(rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .ctrl_tick(ctrl_tick),
		.own_position(own_position), .master_position(master_position),
		.cam_start_pin(cam_start_pin), .seq_flag75(seq_flag75),
		.cam_active_flag(cam_active_flag), .cam_outputs(cam_outputs),
		.prog_flags(prog_flags), .can_event(can_event)
	);

	ecsu_partner src (
		.clk(clk), .rst(rst), .tick_req(tick_req), .own_step(own_step),
		.mst_step(mst_step), .ctrl_tick(ctrl_tick),
		.own_position(own_position), .master_position(master_position)
	);

	// Free-running control clock, 8 ns period.
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// Counts event pulses so repeated or missing requests show up.
	always @(posedge clk) begin
		if (can_event === 1'b1) ev_cnt <= ev_cnt + 1;
	end

	// Prints the verdict and ends the run.
	task automatic summarize();
		if (bad_count == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Compares one value and reports a mismatch at once.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One Avalon transfer, held until waitrequest is seen low.
	task automatic bus(input logic wr_n, input logic [8:0] a,
			input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr_n;
		avs_read <= !wr_n;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 200);
		q = avs_readdata;
		if (n >= 200) begin
			bad_count++;
			$display("ERROR %0t: bus transfer hung", $time);
		end
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask

	task automatic wr(input logic [8:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	task automatic rd(input logic [8:0] a, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 32'h0000_0000, q);
		chk(q, exp);
	endtask

	// Loads start, end and action of one cam slot.
	task automatic wcam(input logic [3:0] i, input logic [31:0] s,
			input logic [31:0] e, input logic [31:0] a);
		wr({1'b1, i, 4'h0}, s);
		wr({1'b1, i, 4'h4}, e);
		wr({1'b1, i, 4'h8}, a);
	endtask

	// One control cycle, then time for a full scan of the table.
	task automatic tick();
		@(posedge clk);
		tick_req <= 1'b1;
		@(posedge clk);
		tick_req <= 1'b0;
		repeat (80) @(posedge clk);
	endtask

	// Cuts a hang short.
	initial begin
		repeat (8000) @(posedge clk);
		bad_count++;
		$display("ERROR %0t: timeout", $time);
		summarize();
	end

	// Main sequence.
	initial begin
		rst = 1'b1;
		avs_address = 9'h000;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0000_0000;
		cam_start_pin = 1'b0;
		seq_flag75 = 1'b0;
		tick_req = 1'b0;
		own_step = 32'h0000_0064;
		mst_step = 32'h0000_9c40;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rd(ecsu_pkg::OFF_CTRL, 32'h0000_0000);
		rd(ecsu_pkg::OFF_STAT, 32'h0000_0000);
		rd(ecsu_pkg::OFF_OUTS, 32'h0000_0000);
		wr(9'h018, 32'hffff_ffff);
		rd(9'h018, 32'h0000_0000);
		wcam(4'h0, 32'h0000_0064, 32'h0000_00fa, 32'h0009_85e2);
		wcam(4'h1, 32'h0000_0384, 32'h0000_0032, 32'h0002_0000);
		wcam(4'h2, 32'h7fff_ffff, 32'h0000_0000, 32'h0020_0000);
		rd(9'h120, 32'h7fff_ffff);
		rd(9'h108, 32'h0009_85e2);
		wr(ecsu_pkg::OFF_CYCLE, 32'h0000_03e8);
		wr(ecsu_pkg::OFF_HYST, 32'h0000_003c);
		wr(ecsu_pkg::OFF_CTRL, 32'h0000_0022);
		cam_start_pin <= 1'b1;
		repeat (8) @(posedge clk);
		rd(ecsu_pkg::OFF_STAT, 32'h0000_0001);
		rd(ecsu_pkg::OFF_POS, 32'h0000_0000);
		// Ten cycles of 100 walk once round a 1000 cycle; cam 2 is beyond
		// the count and must never switch output 5.
		for (int k = 1; k <= 10; k++) begin
			tick();
			p = 32'((k * 100) % 1000);
			a0 = (p >= 32'd100 && p <= 32'd310);
			a1 = (p >= 32'd900 || p <= 32'd50);
			chk({16'h0000, cam_outputs}, (a0 ? 32'h0000_0009 : 32'h0000_0000)
				| (a1 ? 32'h0000_0002 : 32'h0000_0000));
			chk({16'h0000, cam_active_flag}, {30'h0, a1, a0});
			chk({30'h0, prog_flags[98], prog_flags[5]},
				{30'h0, a0, a0});
			rd(ecsu_pkg::OFF_POS, p);
		end
		chk(32'(ev_cnt), 32'h0000_0002);
		cam_start_pin <= 1'b0;
		repeat (8) @(posedge clk);
		rd(ecsu_pkg::OFF_STAT, 32'h0000_0000);
		chk({16'h0000, cam_outputs}, 32'h0000_0000);
		chk({31'h0, |prog_flags}, 32'h0000_0000);
		// Master source, raw increments, started and stopped by flag 75.
		wr(ecsu_pkg::OFF_CTRL, 32'h0000_0012);
		seq_flag75 <= 1'b1;
		repeat (4) @(posedge clk);
		rd(ecsu_pkg::OFF_STAT, 32'h0000_0003);
		rd(ecsu_pkg::OFF_POS, 32'h0000_0000);
		tick();
		rd(ecsu_pkg::OFF_POS, 32'h0000_9c40);
		tick();
		rd(ecsu_pkg::OFF_POS, 32'h0000_3880);
		seq_flag75 <= 1'b0;
		repeat (4) @(posedge clk);
		// The stop keeps the origin bit of the flag start until a new start.
		rd(ecsu_pkg::OFF_STAT, 32'h0000_0002);
		// A zero count stops a running unit and refuses a new start.
		wr(ecsu_pkg::OFF_CTRL, 32'h0000_0022);
		cam_start_pin <= 1'b1;
		repeat (8) @(posedge clk);
		rd(ecsu_pkg::OFF_STAT, 32'h0000_0001);
		wr(ecsu_pkg::OFF_CTRL, 32'h0000_0020);
		rd(ecsu_pkg::OFF_STAT, 32'h0000_0000);
		cam_start_pin <= 1'b0;
		repeat (8) @(posedge clk);
		cam_start_pin <= 1'b1;
		repeat (8) @(posedge clk);
		rd(ecsu_pkg::OFF_STAT, 32'h0000_0000);
		summarize();
	end
endmodule
